// file: logic/conv_control.sv
// Purpose: control logic of an 8-bit voltage-output converter
// Assumes: one clock (peripheral clock), APB slave registers
// Notes: analog core and buffer live outside; this drives their controls
`timescale 1ns/1ns
`default_nettype none
module conv_control #(
  parameter bit HAS_PIN = 1'b1,
  parameter int STARTUP = conv_pkg::STARTUP_CYCLES
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic clk_en,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [1:0] sleep_mode,
  output logic core_power,
  output logic buffer_power,
  output logic pin_drive,
  output logic internal_valid,
  output logic [7:0] hold_code,
  output logic convert_start
);
  ////////////////////////////////////////////////////////////////////////
  logic [7:0] ctrl_q, ctrl_d, value_q, value_d, hold_q, hold_d;
  logic [31:0] prdata_q, prdata_d;
  logic ready_q, ready_d, err_q, err_d, start_q, start_d;
  logic core_q, core_d, buf_q, buf_d, pin_q, pin_d, int_q, int_d;
  logic stopped_q, stopped_d, pend_q, pend_d;
  logic [15:0] wait_q, wait_d;
  logic [1:0] smode_q;
  logic access, wr, rd, hit, ctrl_wr, val_wr, en, sby_off, pd;

  // access phase; slave answers in the second access cycle, one wait state
  assign access = psel && penable && !ready_q;
  assign hit = paddr == conv_pkg::CONTROL_ADDR ||
               paddr == conv_pkg::VALUE_ADDR ||
               paddr == conv_pkg::SLEEP_ADDR;
  assign wr = access && pwrite && hit && pstrb[0];
  assign rd = access && !pwrite;
  assign ctrl_wr = wr && paddr == conv_pkg::CONTROL_ADDR;
  assign val_wr = wr && paddr == conv_pkg::VALUE_ADDR;
  assign en = ctrl_q[conv_pkg::ENABLE_BIT];
  // sleep mode comes from the same clock domain's power manager
  assign pd = smode_q == 2'(conv_pkg::SLEEP_POWERDOWN);
  assign sby_off = smode_q == 2'(conv_pkg::SLEEP_STANDBY) &&
                   !ctrl_q[conv_pkg::STANDBY_BIT];

  ////////////////////////////////////////////////////////////////////////
  always_comb begin
    ctrl_d = ctrl_q;
    value_d = value_q;
    hold_d = hold_q;
    start_d = 1'b0;
    prdata_d = prdata_q;
    ready_d = access;
    err_d = access && !hit;
    stopped_d = stopped_q;
    pend_d = pend_q;
    wait_d = wait_q;
    if (ctrl_wr) begin
      ctrl_d = pwdata[7:0] & conv_pkg::CONTROL_WMASK;
      if (!HAS_PIN) begin
        ctrl_d[conv_pkg::BUFFER_BIT] = 1'b0;
      end
    end
    if (val_wr) begin
      value_d = pwdata[7:0];
    end
    if (rd) begin
      case (paddr)
        conv_pkg::CONTROL_ADDR: prdata_d = {24'h0, ctrl_q};
        conv_pkg::VALUE_ADDR: prdata_d = {24'h0, value_q};
        conv_pkg::SLEEP_ADDR: prdata_d = {29'h0, stopped_q, smode_q};
        default: prdata_d = 32'h0;
      endcase
    end
    // starts requested by software
    if ((val_wr && en) ||
        (ctrl_wr && pwdata[conv_pkg::ENABLE_BIT])) begin
      pend_d = 1'b1;
    end
    if (!ctrl_d[conv_pkg::ENABLE_BIT]) begin
      pend_d = 1'b0;
    end
    if (pd || sby_off) begin
      stopped_d = 1'b1;
      wait_d = 16'(STARTUP);
    end else if (stopped_q) begin
      stopped_d = 1'b0;
      pend_d = pend_d || en;
    end else if (wait_q != 16'h0) begin
      wait_d = wait_q - 16'h1;
    end else if (pend_d) begin
      // latch the value being written this cycle, if any
      hold_d = value_d;
      start_d = 1'b1;
      pend_d = 1'b0;
    end
  end

  always_comb begin
    core_d = en && !(pd || sby_off);
    buf_d = core_d && ctrl_q[conv_pkg::BUFFER_BIT] && HAS_PIN;
    pin_d = buf_d;
    int_d = core_d;
  end

  // no debug-halt input exists: halting the CPU cannot alter this
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_q <= conv_pkg::CONTROL_RESET;
      value_q <= conv_pkg::VALUE_RESET;
      hold_q <= conv_pkg::VALUE_RESET;
      prdata_q <= 32'h0;
      ready_q <= 1'b0;
      err_q <= 1'b0;
      start_q <= 1'b0;
      core_q <= 1'b0;
      buf_q <= 1'b0;
      pin_q <= 1'b0;
      int_q <= 1'b0;
      stopped_q <= 1'b0;
      pend_q <= 1'b0;
      wait_q <= 16'h0;
      smode_q <= 2'h0;
    end else if (clk_en) begin
      ctrl_q <= ctrl_d;
      value_q <= value_d;
      hold_q <= hold_d;
      prdata_q <= prdata_d;
      ready_q <= ready_d;
      err_q <= err_d;
      start_q <= start_d;
      core_q <= core_d;
      buf_q <= buf_d;
      pin_q <= pin_d;
      int_q <= int_d;
      stopped_q <= stopped_d;
      pend_q <= pend_d;
      wait_q <= wait_d;
      smode_q <= sleep_mode;
    end
  end

  assign prdata = prdata_q;
  assign pready = ready_q;
  assign pslverr = err_q;
  assign core_power = core_q;
  assign buffer_power = buf_q;
  assign pin_drive = pin_q;
  assign internal_valid = int_q;
  assign hold_code = hold_q;
  assign convert_start = start_q;

  ////////////////////////////////////////////////////////////////////////
  AST_DATA_START: assert property (@(posedge clk) disable iff (!rst_n)
    clk_en && val_wr && en && !pd && !sby_off && !stopped_q &&
    wait_q == 16'h0 |=> convert_start && hold_code == $past(pwdata[7:0]))
    else $error("enabled data write did not start conversion");
  AST_NO_START_OFF: assert property (@(posedge clk) disable iff (!rst_n)
    clk_en && val_wr && !en && !ctrl_wr |=> !convert_start)
    else $error("disabled data write started conversion");
  AST_ENABLE_ON: assert property (@(posedge clk) disable iff (!rst_n)
    clk_en && ctrl_wr |=> en == $past(pwdata[0]))
    else $error("enable bit not written");
  AST_HOLD_STABLE: assert property (@(posedge clk) disable iff (!rst_n)
    !convert_start |-> $stable(hold_code))
    else $error("holding register changed without a start");
  AST_POWERDOWN: assert property (@(posedge clk) disable iff (!rst_n)
    clk_en && pd |=> !core_power && !buffer_power)
    else $error("power-down left converter on");
  AST_STANDBY_OFF: assert property (@(posedge clk) disable iff (!rst_n)
    clk_en && sby_off |=> !core_power && !convert_start)
    else $error("standby did not stop converter");
  AST_STANDBY_ON: assert property (@(posedge clk) disable iff (!rst_n)
    clk_en && en && smode_q == 2'(conv_pkg::SLEEP_STANDBY) &&
    ctrl_q[conv_pkg::STANDBY_BIT] |=> core_power)
    else $error("keep-on standby lost converter");
  AST_BUFFER: assert property (@(posedge clk) disable iff (!rst_n)
    pin_drive |-> core_power && buffer_power && HAS_PIN)
    else $error("pin driven without buffer");
  AST_INTERNAL: assert property (@(posedge clk) disable iff (!rst_n)
    clk_en && en && !pd && !sby_off |=> internal_valid)
    else $error("internal output not offered");
  AST_WAKE_DELAY: assert property (@(posedge clk) disable iff (!rst_n)
    clk_en && stopped_q && !pd && !sby_off |=> !convert_start)
    else $error("conversion without start-up delay");

  ////////////////////////////////////////////////////////////////////////
  // bus handshake: one-cycle answer, error only with ready
  AST_READY_ONE: assert property (
    @(posedge clk) disable iff (!rst_n) pready |=> !pready)
    else $error("ready held longer than one cycle");
  AST_ERR_WITH_READY: assert property (
    @(posedge clk) disable iff (!rst_n) pslverr |-> pready)
    else $error("error flagged without ready");
  AST_IDLE_NO_READY: assert property (
    @(posedge clk) disable iff (!rst_n) clk_en && !access |=> !pready)
    else $error("ready without an access");
  AST_UNMAPPED: assert property (
    @(posedge clk) disable iff (!rst_n)
    clk_en && access && !hit |=> pslverr && pready)
    else $error("unmapped access not flagged");
  AST_MAPPED_OK: assert property (
    @(posedge clk) disable iff (!rst_n)
    clk_en && access && hit |=> !pslverr)
    else $error("mapped access flagged as error");
  AST_READ_CTRL: assert property (
    @(posedge clk) disable iff (!rst_n)
    clk_en && rd && paddr == conv_pkg::CONTROL_ADDR |=>
    prdata == {24'h0, $past(ctrl_q)})
    else $error("control read data wrong");
  AST_READ_VALUE: assert property (
    @(posedge clk) disable iff (!rst_n)
    clk_en && rd && paddr == conv_pkg::VALUE_ADDR |=>
    prdata == {24'h0, $past(value_q)})
    else $error("value read data wrong");
  AST_VALUE_WRITE: assert property (
    @(posedge clk) disable iff (!rst_n)
    clk_en && val_wr |=> value_q == $past(pwdata[7:0]))
    else $error("value write lost");
  AST_VALUE_KEEP: assert property (
    @(posedge clk) disable iff (!rst_n)
    !(clk_en && val_wr) |=> $stable(value_q))
    else $error("value changed without a write");
  AST_STROBE: assert property (
    @(posedge clk) disable iff (!rst_n)
    clk_en && access && pwrite && !pstrb[0] |=>
    $stable(value_q) && $stable(ctrl_q))
    else $error("write without lane 0 took effect");
  AST_CTRL_MASK: assert property (
    @(posedge clk) disable iff (!rst_n)
    (ctrl_q & ~conv_pkg::CONTROL_WMASK) == 8'h00)
    else $error("reserved control bit set");
  // clock enable low must freeze the control, value and holding registers
  AST_FREEZE: assert property (
    @(posedge clk) disable iff (!rst_n)
    !clk_en |=> $stable(ctrl_q) && $stable(value_q) && $stable(hold_q))
    else $error("state moved while clock enable low");

  // conversion starts
  AST_START_PULSE: assert property (
    @(posedge clk) disable iff (!rst_n)
    clk_en && convert_start |=> !convert_start)
    else $error("start longer than one cycle");
  AST_START_NEEDS_EN: assert property (
    @(posedge clk) disable iff (!rst_n) convert_start |-> en)
    else $error("start while disabled");
  AST_ENABLE_START: assert property (
    @(posedge clk) disable iff (!rst_n)
    clk_en && ctrl_wr && pwdata[0] && !pd && !sby_off && !stopped_q &&
    wait_q == 16'h0 |=> convert_start && hold_code == $past(value_q))
    else $error("enable write did not start conversion");
  AST_DISABLE_NO_START: assert property (
    @(posedge clk) disable iff (!rst_n)
    clk_en && ctrl_wr && !pwdata[0] |=> !convert_start)
    else $error("start after disable write");
  AST_HOLD_ON_START: assert property (
    @(posedge clk) disable iff (!rst_n)
    convert_start |-> hold_code == value_q)
    else $error("holding register differs from value at start");
  AST_WAIT_BLOCKS: assert property (
    @(posedge clk) disable iff (!rst_n)
    clk_en && wait_q != 16'h0 |=> !convert_start)
    else $error("start during start-up wait");
  AST_WAIT_LOAD: assert property (
    @(posedge clk) disable iff (!rst_n)
    clk_en && (pd || sby_off) |=> wait_q == 16'(STARTUP))
    else $error("start-up wait not loaded on stop");
  AST_PD_STOPS: assert property (
    @(posedge clk) disable iff (!rst_n)
    clk_en && pd |=> !convert_start)
    else $error("start in power-down");

  // power and routing of the analog parts
  AST_CORE_NEEDS_EN: assert property (
    @(posedge clk) disable iff (!rst_n) clk_en && !en |=> !core_power)
    else $error("core powered while disabled");
  AST_BUF_NEEDS_CORE: assert property (
    @(posedge clk) disable iff (!rst_n) buffer_power |-> core_power)
    else $error("buffer powered without core");
  AST_PIN_EQ_BUF: assert property (
    @(posedge clk) disable iff (!rst_n) pin_drive == buffer_power)
    else $error("pin routing differs from buffer power");
  AST_BUF_OFF_BIT: assert property (
    @(posedge clk) disable iff (!rst_n)
    clk_en && !ctrl_q[conv_pkg::BUFFER_BIT] |=> !buffer_power)
    else $error("buffer on with enable bit clear");
  AST_NO_PIN_INST: assert property (
    @(posedge clk) disable iff (!rst_n)
    !HAS_PIN |-> !buffer_power && !pin_drive)
    else $error("pin buffer in an internal-only unit");
  AST_INT_EQ_CORE: assert property (
    @(posedge clk) disable iff (!rst_n) internal_valid == core_power)
    else $error("internal output differs from core power");
  AST_STANDBY_BUF: assert property (
    @(posedge clk) disable iff (!rst_n)
    clk_en && sby_off |=> !buffer_power)
    else $error("buffer left on in standby");
  AST_WAKE_CORE: assert property (
    @(posedge clk) disable iff (!rst_n)
    clk_en && stopped_q && en && !pd && !sby_off |=> core_power)
    else $error("core not re-enabled on wake");
endmodule // conv_control
`default_nettype wire

// file: pkg/conv_pkg.sv
// Purpose: shared constants for the converter control block
// Assumes: APB slave, 32-bit data, one register per aligned word
// Notes: offsets are printed indices; byte address is four times index
`default_nettype none
package conv_pkg;
  localparam logic [7:0] CONTROL_INDEX = 8'h00;
  localparam logic [7:0] VALUE_INDEX = 8'h01;
  localparam logic [7:0] SLEEP_INDEX = 8'h02;
  localparam logic [11:0] CONTROL_ADDR = {2'h0, CONTROL_INDEX, 2'h0};
  localparam logic [11:0] VALUE_ADDR = {2'h0, VALUE_INDEX, 2'h0};
  localparam logic [11:0] SLEEP_ADDR = {2'h0, SLEEP_INDEX, 2'h0};
  localparam int ENABLE_BIT = 0;
  localparam int BUFFER_BIT = 6;
  localparam int STANDBY_BIT = 7;
  localparam logic [7:0] CONTROL_WMASK = 8'hC1;
  localparam logic [7:0] CONTROL_RESET = 8'h00;
  localparam logic [7:0] VALUE_RESET = 8'h00;
  localparam int CLK_HZ = 20000000;
  localparam int STARTUP_NS = 1000;
  localparam int STARTUP_CYCLES =
    (STARTUP_NS * (CLK_HZ / 1000000) + 999) / 1000;
  typedef enum logic [1:0] {
    SLEEP_ACTIVE, SLEEP_IDLE, SLEEP_STANDBY, SLEEP_POWERDOWN
  } sleep_mode_t;
endpackage
`default_nettype wire

// file: testbench/analog_model.sv
// Purpose: behavioural analog core seen from the control block
// Assumes: convert_start is a one-cycle pulse on clk
// Notes: counts every start, powered or not, so stray starts show
`timescale 1ns/1ns
`default_nettype none
module analog_model (
  input wire logic clk,
  input wire logic convert_start,
  input wire logic [7:0] hold_code,
  output logic [7:0] out_code,
  output int starts
);
  initial starts = 0;
  always @(posedge clk) begin
    if (convert_start) begin
      starts <= starts + 1;
      out_code <= hold_code;
    end
  end
endmodule // analog_model
`default_nettype wire

// file: testbench/testbench.sv
// Purpose: self-checking bench for the converter control block
// Assumes: one wait state on every register access
// Notes: short start-up count keeps the wake checks brief
`timescale 1ns/1ns
`default_nettype none
module testbench;
  logic clk, rst_n, psel, penable, pwrite, pready, pslverr, err;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [1:0] sleep_mode;
  logic core_power, buffer_power, pin_drive, internal_valid, convert_start;
  logic [7:0] hold_code, out_code;
  int starts, miscompares, n_checks, s0;
  logic clk_en;
  logic [3:0] pstrb;
  conv_control #(.HAS_PIN(1'b1), .STARTUP(2)) u_conv_control (
    .clk(clk), .rst_n(rst_n), .clk_en(clk_en), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .sleep_mode(sleep_mode), .core_power(core_power),
    .buffer_power(buffer_power), .pin_drive(pin_drive),
    .internal_valid(internal_valid), .hold_code(hold_code),
    .convert_start(convert_start));
  analog_model u_analog_model (.clk(clk), .convert_start(convert_start),
    .hold_code(hold_code), .out_code(out_code), .starts(starts));
  ////////////////////////////////////////////////////////////////////////
  task automatic summarize();
    $display("checks %0d mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("ERROR %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask
  // read data and error are taken at the edge that sees pready
  task automatic apb(input logic w, input logic [11:0] a,
    input logic [31:0] d);
    int i;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    i = 0;
    do begin
      @(posedge clk);
      i++;
    end while (pready !== 1'b1 && i < 20);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (pready !== 1'b1) begin
      miscompares++;
      summarize();
    end
  endtask
  ////////////////////////////////////////////////////////////////////////
  task automatic sc_reset();
    apb(1'b0, conv_pkg::CONTROL_ADDR, 32'h0);
    chk(rd, 32'h0);
    apb(1'b0, conv_pkg::VALUE_ADDR, 32'h0);
    chk(rd, 32'h0);
  endtask
  task automatic sc_store_enable();
    s0 = starts;
    apb(1'b1, conv_pkg::VALUE_ADDR, 32'h0000005A);
    apb(1'b0, conv_pkg::VALUE_ADDR, 32'h0);
    chk(rd, 32'h0000005A);
    chk(starts, s0);
    apb(1'b1, conv_pkg::CONTROL_ADDR, 32'h00000041);
    cyc(6);
    chk(starts, s0 + 1);
    chk(out_code, 8'h5A);
    chk(internal_valid, 1'b1);
    chk(pin_drive & buffer_power, 1'b1);
    apb(1'b1, conv_pkg::VALUE_ADDR, 32'h000000A5);
    cyc(2);
    chk(starts, s0 + 2);
    chk(hold_code, 8'hA5);
  endtask
  task automatic sc_sleep();
    apb(1'b1, conv_pkg::CONTROL_ADDR, 32'h000000C1);
    sleep_mode <= conv_pkg::SLEEP_STANDBY;
    cyc(4);
    chk(core_power & buffer_power, 1'b1);
    clk_en <= 1'b0;
    sleep_mode <= conv_pkg::SLEEP_POWERDOWN;
    cyc(4);
    chk(core_power, 1'b1);
    clk_en <= 1'b1;
    sleep_mode <= conv_pkg::SLEEP_POWERDOWN;
    cyc(4);
    chk(core_power | buffer_power, 1'b0);
    sleep_mode <= conv_pkg::SLEEP_ACTIVE;
    cyc(8);
    apb(1'b1, conv_pkg::CONTROL_ADDR, 32'h00000041);
    sleep_mode <= conv_pkg::SLEEP_STANDBY;
    cyc(4);
    chk(core_power | buffer_power, 1'b0);
    s0 = starts;
    sleep_mode <= conv_pkg::SLEEP_ACTIVE;
    cyc(8);
    chk(core_power & buffer_power, 1'b1);
    chk(starts, s0 + 1);
  endtask
  task automatic sc_off();
    apb(1'b1, conv_pkg::CONTROL_ADDR, 32'h0);
    cyc(2);
    chk(internal_valid, 1'b0);
    apb(1'b0, 12'h0FC, 32'h0);
    chk({rd[30:0], err}, 32'h1);
    pstrb <= 4'h0;
    apb(1'b1, conv_pkg::VALUE_ADDR, 32'h00000033);
    pstrb <= 4'hF;
    apb(1'b0, conv_pkg::VALUE_ADDR, 32'h0);
    chk(rd, 32'h000000A5);
  endtask
  ////////////////////////////////////////////////////////////////////////
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  initial begin
    rst_n = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    clk_en = 1'b1;
    pstrb = 4'hF;
    sleep_mode = conv_pkg::SLEEP_ACTIVE;
    miscompares = 0;
    n_checks = 0;
    cyc(4);
    rst_n <= 1'b1;
    sc_reset();
    sc_store_enable();
    sc_sleep();
    sc_off();
    summarize();
  end
endmodule // testbench
`default_nettype wire
